// >>> shared/hpp_pkg.sv
// package: constants shared by both ends of the parallel host port
package hpp_pkg;

  // -----------------------------------------------------------------
  // widths and address map
  // -----------------------------------------------------------------
  localparam int unsigned ADDR_W       = 15;
  localparam int unsigned DATA_W       = 8;
  localparam logic [14:0] COMMON_BASE  = 15'h0000;
  localparam logic [14:0] SOCKET_BASE  = 15'h0400;
  localparam logic [14:0] SOCKET_END   = 15'h07ff;
  localparam logic [14:0] TXMEM_BASE   = 15'h4000;
  localparam logic [14:0] RXMEM_BASE   = 15'h6000;
  localparam logic [14:0] COMMON_FLAGS = 15'h0015;
  localparam logic [14:0] COMMON_MASK  = 15'h0016;
  localparam logic [7:0]  SOCK_FLAGS   = 8'h02;
  localparam int unsigned COMMON_WORDS = 64;
  localparam int unsigned SOCK_WORDS   = 64;
  localparam int unsigned MEM_WORDS    = 256;
  localparam int unsigned NUM_SOCK     = 4;
  localparam logic [7:0]  RESET_BYTE   = 8'h00;
  localparam logic [7:0]  MASK_RESET   = 8'h00;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned RESET_HOLD_US = 125;
  localparam int unsigned RESET_CYCLES  = RESET_HOLD_US * CLK_MHZ;
  localparam int unsigned LOCK_CYCLES   = 64;
  localparam int unsigned STROBE_CYCLES = 4;

  // host command codes
  localparam logic [1:0] CMD_NONE  = 2'h0;
  localparam logic [1:0] CMD_READ  = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;

  // address region decode used by the controller end
  function automatic logic [1:0] hpp_region(input logic [14:0] a);
    if (a >= RXMEM_BASE) return 2'h3;
    else if (a >= TXMEM_BASE) return 2'h2;
    else if (a >= SOCKET_BASE && a <= SOCKET_END) return 2'h1;
    else return 2'h0;
  endfunction

endpackage

// >>> shared/hpp_bus_if.sv
// interface: pins between the microcontroller and the controller
`timescale 1ns/1ps
`default_nettype none
interface hpp_bus_if;
  logic [14:0] addr;
  logic [7:0]  data_host;
  logic        data_host_oe;
  logic [7:0]  data_dev;
  logic        data_dev_oe;
  logic [7:0]  data_in;
  logic        cs_n;
  logic        rd_n;
  logic        wr_n;
  logic        reset_n;
  logic        int_n;
  logic        pll_locked;
  logic        duplex_select_n;

  // resolved data wire; an undriven bus floats high through the pull-up
  assign data_in = data_dev_oe ? data_dev : (data_host_oe ? data_host : 8'hff);

  modport dev  (input addr, data_in, cs_n, rd_n, wr_n, reset_n, duplex_select_n,
                output data_dev, data_dev_oe, int_n, pll_locked);
  modport host (input data_in, int_n, pll_locked,
                output addr, data_host, data_host_oe, cs_n, rd_n, wr_n, reset_n);
endinterface
`default_nettype wire

// >>> core/hpp_device.sv
// module: controller end of the parallel host port
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module hpp_device
  import hpp_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  hpp_bus_if.dev           bus,
  input  wire logic [3:0]  sock_event,
  input  wire logic [1:0]  sock_event_kind,
  input  wire logic        common_event,
  output logic             full_duplex,
  output logic             ready
);
  import hpp_pkg::*;

  // -----------------------------------------------------------------
  // pin synchronisers and state
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    HPP_LOCKING = 2'b01,
    HPP_RUN     = 2'b10
  } hpp_dev_state_t;

  typedef struct packed {
    logic [2:0]     cs_s1, cs_s2;
    logic [2:0]     rd_s1, rd_s2;
    logic           rst_s1, rst_s2;
    logic           dpx_s1, dpx_s2;
    logic           wr_last;
    logic           rd_last;
    logic [14:0]    addr_q;
    logic [7:0]     wdata_q;
    logic [7:0]     rdata;
    logic           rd_oe;
    logic [7:0]     common_flags;
    logic [7:0]     common_mask;
    logic [3:0][7:0] sock_flags;
    logic           full_duplex;
    logic [15:0]    rst_cnt;
    logic           soft_reset;
    logic [6:0]     lock_cnt;
    hpp_dev_state_t state;
  } hpp_dev_reg_t;

  hpp_dev_reg_t r, next_r;

  // storage for plain registers and the two buffers
  logic [7:0] common_mem [COMMON_WORDS];
  logic [7:0] sock_mem   [NUM_SOCK][SOCK_WORDS];
  logic [7:0] tx_mem     [MEM_WORDS];
  logic [7:0] rx_mem     [MEM_WORDS];

  // synchronised strobes and derived events
  logic       cs_act, rd_act, wr_act, wr_rise, rd_fall;
  logic [1:0] region;
  logic [7:0] read_val;
  logic [3:0] sock_pend;

  assign cs_act  = ~r.cs_s2[0];
  assign rd_act  = cs_act & ~r.rd_s2[0];
  assign wr_act  = cs_act & ~r.cs_s2[1];
  assign wr_rise = r.wr_last & ~wr_act;
  assign rd_fall = rd_act & ~r.rd_last;
  assign region  = hpp_region(r.addr_q);

  // read mux over the four regions
  always_comb
  begin
    read_val = RESET_BYTE;
    if (r.addr_q == COMMON_FLAGS)
      read_val = r.common_flags;
    else if (r.addr_q == COMMON_MASK)
      read_val = r.common_mask;
    else if (region == 2'h0)
      read_val = common_mem[r.addr_q[5:0]];
    else if (region == 2'h1 && r.addr_q[7:0] == SOCK_FLAGS)
      read_val = r.sock_flags[r.addr_q[9:8]];
    else if (region == 2'h1)
      read_val = sock_mem[r.addr_q[9:8]][r.addr_q[5:0]];
    else if (region == 2'h2)
      read_val = tx_mem[r.addr_q[7:0]];
    else
      read_val = rx_mem[r.addr_q[7:0]];
  end

  // -----------------------------------------------------------------
  // next-state logic
  // -----------------------------------------------------------------
  always_comb
  begin
    next_r        = r;
    next_r.cs_s1  = {1'b1, bus.wr_n, bus.cs_n};
    next_r.cs_s2  = r.cs_s1;
    next_r.rd_s1  = {2'b11, bus.rd_n};
    next_r.rd_s2  = r.rd_s1;
    next_r.rst_s1 = bus.reset_n;
    next_r.rst_s2 = r.rst_s1;
    next_r.dpx_s1 = bus.duplex_select_n;
    next_r.dpx_s2 = r.dpx_s1;
    next_r.wr_last = wr_act;
    next_r.rd_last = rd_act;
    next_r.soft_reset = 1'b0;
    // address sampled every cycle; select and strobe fall together, so a
    // strobe-gated capture would hand the read mux last access's address
    next_r.addr_q  = bus.addr;
    if (wr_act)
      next_r.wdata_q = bus.data_in;
    if (rd_fall)
      next_r.rdata = read_val;
    next_r.rd_oe = rd_act;
    // event flags: hardware set wins over read clear
    if (rd_fall && r.addr_q == COMMON_FLAGS)
      next_r.common_flags = 8'h00;
    if (wr_rise && r.addr_q == COMMON_MASK)
      next_r.common_mask = r.wdata_q;
    for (int s = 0; s < NUM_SOCK; s++)
    begin
      if (rd_fall && region == 2'h1 && r.addr_q[9:8] == 2'(s)
          && r.addr_q[7:0] == SOCK_FLAGS)
        next_r.sock_flags[s] = 8'h00;
      if (sock_event[s])
        next_r.sock_flags[s][sock_event_kind] = 1'b1;
      if (r.sock_flags[s] != 8'h00 || sock_event[s])
        next_r.common_flags[s] = 1'b1;
    end
    if (common_event)
      next_r.common_flags[7] = 1'b1;
    // reset pin held long enough restarts the controller
    if (!r.rst_s2)
    begin
      if (r.rst_cnt < 16'(RESET_CYCLES))
        next_r.rst_cnt = r.rst_cnt + 16'h0001;
    end
    else
    begin
      next_r.soft_reset = (r.rst_cnt >= 16'(RESET_CYCLES));
      next_r.rst_cnt    = 16'h0000;
    end
    case (r.state)
      HPP_LOCKING:
      begin
        next_r.lock_cnt = r.lock_cnt + 7'h01;
        if (r.lock_cnt == 7'(LOCK_CYCLES - 1))
        begin
          next_r.state       = HPP_RUN;
          next_r.full_duplex = ~r.dpx_s2;
        end
      end
      HPP_RUN:
        next_r.lock_cnt = r.lock_cnt;
      default:
        next_r.state = HPP_LOCKING;
    endcase
    // no lock reported while the reset pin is held; reset beats the sequencer
    if (!r.rst_s2)
    begin
      next_r.state    = HPP_LOCKING;
      next_r.lock_cnt = 7'h00;
    end
    if (r.soft_reset)
    begin
      next_r.common_flags = 8'h00;
      next_r.common_mask  = MASK_RESET;
      next_r.sock_flags   = '0;
      next_r.lock_cnt     = 7'h00;
      next_r.state        = HPP_LOCKING;
      next_r.full_duplex  = ~r.dpx_s2;
    end
  end

  // -----------------------------------------------------------------
  // registers; one clock for the whole controller
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r        <= '0;
      r.cs_s1  <= 3'b111;
      r.cs_s2  <= 3'b111;
      r.rd_s1  <= 3'b111;
      r.rd_s2  <= 3'b111;
      r.rst_s1 <= 1'b1;
      r.rst_s2 <= 1'b1;
      r.dpx_s1 <= 1'b1;
      r.dpx_s2 <= 1'b1;
      r.state  <= HPP_LOCKING;
    end
    else
      r <= next_r;
  end

  // storage writes on the strobe's rising edge; array kept out of the struct
  // register bytes return to defaults on a pin reset; buffers keep contents
  always_ff @(posedge core_clk)
  begin
    if (r.soft_reset)
    begin
      for (int j = 0; j < COMMON_WORDS; j++)
        common_mem[j] <= RESET_BYTE;
      for (int s = 0; s < NUM_SOCK; s++)
        for (int j = 0; j < SOCK_WORDS; j++)
          sock_mem[s][j] <= RESET_BYTE;
    end
    else if (wr_rise && region == 2'h0)
      common_mem[r.addr_q[5:0]] <= r.wdata_q;
    else if (wr_rise && region == 2'h1)
      sock_mem[r.addr_q[9:8]][r.addr_q[5:0]] <= r.wdata_q;
    else if (wr_rise && region == 2'h2)
      tx_mem[r.addr_q[7:0]] <= r.wdata_q;
    else if (wr_rise)
      rx_mem[r.addr_q[7:0]] <= r.wdata_q;
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  for (genvar g = 0; g < NUM_SOCK; g++)
  begin : g_pend
    assign sock_pend[g] = r.common_flags[g] & r.common_mask[g];
  end

  assign bus.int_n       = ~(|sock_pend | (r.common_flags[7] & r.common_mask[7]));
  assign bus.data_dev    = r.rdata;
  assign bus.data_dev_oe = r.rd_oe & rd_act;
  assign bus.pll_locked  = (r.state == HPP_RUN);
  assign full_duplex     = r.full_duplex;
  assign ready           = (r.state == HPP_RUN);
endmodule // hpp_device
`default_nettype wire

// >>> core/hpp_host.sv
// module: microcontroller end that drives the parallel host port
`timescale 1ns/1ps
`default_nettype none
module hpp_host
  import hpp_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  hpp_bus_if.host          bus,
  input  wire logic [14:0] cmd_addr,
  input  wire logic [7:0]  cmd_wdata,
  input  wire logic [1:0]  cmd,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  output logic [7:0]       rsp_data,
  output logic             rsp_valid,
  output logic             irq,
  output logic             dev_ready
);
  import hpp_pkg::*;

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef enum logic [3:0] {
    HH_RESET = 4'b0001,
    HH_IDLE  = 4'b0010,
    HH_STRB  = 4'b0100,
    HH_GAP   = 4'b1000
  } hpp_host_state_t;

  typedef struct packed {
    hpp_host_state_t state;
    logic [15:0]     cnt;
    logic [14:0]     addr;
    logic [7:0]      wdata;
    logic            is_wr;
    logic            cs_n, rd_n, wr_n, oe, reset_n;
    logic [7:0]      rsp_data;
    logic            rsp_valid;
    logic            int_s1, int_s2, lk_s1, lk_s2;
    logic [7:0]      din_s1, din_s2;
  } hpp_host_reg_t;

  hpp_host_reg_t r, next_r;

  // -----------------------------------------------------------------
  // sequencer: reset pulse, then one strobe per command
  // -----------------------------------------------------------------
  always_comb
  begin
    next_r           = r;
    next_r.rsp_valid = 1'b0;
    next_r.int_s1    = bus.int_n;
    next_r.int_s2    = r.int_s1;
    next_r.lk_s1     = bus.pll_locked;
    next_r.lk_s2     = r.lk_s1;
    next_r.din_s1    = bus.data_in;
    next_r.din_s2    = r.din_s1;
    case (r.state)
      HH_RESET:
      begin
        // hold reset longer than the controller's minimum
        next_r.cnt = r.cnt + 16'h0001;
        if (r.cnt == 16'(RESET_CYCLES + 8))
        begin
          next_r.reset_n = 1'b1;
          next_r.state   = HH_IDLE;
        end
      end
      HH_IDLE:
      begin
        if (cmd_valid && cmd != CMD_NONE && r.lk_s2)
        begin
          next_r.addr  = cmd_addr;
          next_r.wdata = cmd_wdata;
          next_r.is_wr = (cmd == CMD_WRITE);
          next_r.cs_n  = 1'b0;
          next_r.rd_n  = (cmd == CMD_WRITE);
          next_r.wr_n  = (cmd != CMD_WRITE);
          next_r.oe    = (cmd == CMD_WRITE);
          next_r.cnt   = 16'h0000;
          next_r.state = HH_STRB;
        end
      end
      HH_STRB:
      begin
        // strobe must outlast the far end's synchroniser and capture
        next_r.cnt = r.cnt + 16'h0001;
        if (r.cnt == 16'(STROBE_CYCLES + 2))
        begin
          next_r.rd_n = 1'b1;
          next_r.wr_n = 1'b1;
          next_r.state = HH_GAP;
          next_r.cnt   = 16'h0000;
          if (!r.is_wr)
          begin
            next_r.rsp_data  = r.din_s2;
            next_r.rsp_valid = 1'b1;
          end
        end
      end
      HH_GAP:
      begin
        // keep address and select a few cycles past the rising edge
        next_r.cnt = r.cnt + 16'h0001;
        if (r.cnt == 16'(STROBE_CYCLES))
        begin
          next_r.cs_n  = 1'b1;
          next_r.oe    = 1'b0;
          next_r.state = HH_IDLE;
        end
      end
      default:
        next_r.state = HH_RESET;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r        <= '0;
      r.state  <= HH_RESET;
      r.cs_n   <= 1'b1;
      r.rd_n   <= 1'b1;
      r.wr_n   <= 1'b1;
      r.int_s1 <= 1'b1;
      r.int_s2 <= 1'b1;
    end
    else
      r <= next_r;
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign bus.addr         = r.addr;
  assign bus.data_host    = r.wdata;
  assign bus.data_host_oe = r.oe;
  assign bus.cs_n         = r.cs_n;
  assign bus.rd_n         = r.rd_n;
  assign bus.wr_n         = r.wr_n;
  assign bus.reset_n      = r.reset_n;
  assign cmd_ready        = (r.state == HH_IDLE) & r.lk_s2;
  assign rsp_data         = r.rsp_data;
  assign rsp_valid        = r.rsp_valid;
  assign irq              = ~r.int_s2;
  assign dev_ready        = r.lk_s2;
endmodule // hpp_host
`default_nettype wire

// >>> sim/hpp_asserts.sv
// checker: pin-level timing relations of the parallel host port
`timescale 1ns/1ps
`default_nettype none
module hpp_asserts
(
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic [7:0] data_in,
  input wire logic       data_host_oe,
  input wire logic       data_dev_oe,
  input wire logic       int_n,
  input wire logic       pll_locked
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // -------------------------------------------------------------
  // bus ownership: one driver at a time, only inside an access
  // -------------------------------------------------------------
  a_dev_drive_read: assert property (data_dev_oe |-> !cs_n && wr_n)
    else $error("device drives data outside a read");
  a_no_contention: assert property (!(data_dev_oe && data_host_oe))
    else $error("both ends drive the data bus");
  a_host_drive_write: assert property (data_host_oe |-> !cs_n && rd_n)
    else $error("host drives data outside a write");

  // -------------------------------------------------------------
  // strobes and data
  // -------------------------------------------------------------
  a_strobe_in_select: assert property ((!rd_n || !wr_n) |-> !cs_n)
    else $error("strobe low without chip select");
  a_one_direction: assert property (!(!rd_n && !wr_n))
    else $error("read and write strobes low together");
  a_write_data_held: assert property ($rose(wr_n) |-> data_host_oe && $stable(data_in))
    else $error("write data not steady at strobe release");
  a_read_answer: assert property ($fell(rd_n) |-> ##5 data_dev_oe)
    else $error("device not answering a read");

  // -------------------------------------------------------------
  // reset behaviour: lock settles, no stray interrupt
  // -------------------------------------------------------------
  a_lock_settles: assert property ($rose(rstn) |-> !pll_locked [*8])
    else $error("lock reported during settling");
  a_int_quiet: assert property ($rose(rstn) |-> int_n [*8])
    else $error("interrupt active straight after reset");
endmodule // hpp_asserts
`default_nettype wire

// >>> sim/testbench.sv
// testbench: host and device ends joined through the pin interface
`timescale 1ns/1ps
`default_nettype none
module testbench
  import hpp_pkg::*;
;
  logic        core_clk;
  logic        rstn;
  logic [14:0] cmd_addr;
  logic [7:0]  cmd_wdata;
  logic [1:0]  cmd;
  logic        cmd_valid;
  logic        cmd_ready;
  logic [7:0]  rsp_data;
  logic        rsp_valid;
  logic        irq;
  logic        dev_ready;
  logic [3:0]  sock_event;
  logic [1:0]  sock_event_kind;
  logic        common_event;
  logic        full_duplex;
  logic        ready;
  logic [8:0]  exp_q[$];
  logic [8:0]  note;
  logic [7:0]  wdat[4];
  logic [14:0] wadr[4];
  logic [14:0] base[4];
  int          fail_count;
  int          samples_checked;
  int          seed;
  int          i;
  int          k;

  hpp_bus_if bus ();
  hpp_device i_hpp_device (.core_clk(core_clk), .rstn(rstn), .bus(bus),
    .sock_event(sock_event), .sock_event_kind(sock_event_kind),
    .common_event(common_event), .full_duplex(full_duplex), .ready(ready));
  hpp_host i_hpp_host (.core_clk(core_clk), .rstn(rstn), .bus(bus),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd(cmd), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid), .irq(irq),
    .dev_ready(dev_ready));
  hpp_asserts i_hpp_asserts (.core_clk(core_clk), .rstn(rstn), .cs_n(bus.cs_n),
    .rd_n(bus.rd_n), .wr_n(bus.wr_n), .data_in(bus.data_in),
    .data_host_oe(bus.data_host_oe), .data_dev_oe(bus.data_dev_oe),
    .int_n(bus.int_n), .pll_locked(bus.pll_locked));

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  // -------------------------------------------------------------
  // reporting and comparison
  // -------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bounded wait; a bound that runs out ends the run
  task automatic wait_level(ref logic sig, input logic lvl, input int lim);
    int n;
    n = 0;
    // let the edge that launched the last request settle before looking
    @(negedge core_clk);
    while (sig !== lvl && n < lim)
    begin
      @(negedge core_clk);
      n++;
    end
    if (sig !== lvl)
    begin
      fail_count++;
      $display("Error wait expected %b seen %b", lvl, sig);
      finish_test();
    end
  endtask

  // -------------------------------------------------------------
  // drivers: read notes carry {check, expected byte}
  // -------------------------------------------------------------
  task automatic host_op(input logic [1:0] c, input logic [14:0] a, input logic [7:0] d,
                         input logic chk);
    wait_level(cmd_ready, 1'b1, 200);
    if (c == CMD_READ)
      exp_q.push_back({chk, d});
    @(posedge core_clk);
    cmd       <= c;
    cmd_addr  <= a;
    cmd_wdata <= d;
    cmd_valid <= 1'b1;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
  endtask

  task automatic pulse_event(input logic [3:0] s, input logic [1:0] kd, input logic c);
    @(posedge core_clk);
    sock_event      <= s;
    sock_event_kind <= kd;
    common_event    <= c;
    @(posedge core_clk);
    sock_event   <= 4'h0;
    common_event <= 1'b0;
  endtask

  // reset aborts any access in flight, so pending notes are dropped
  task automatic do_reset(input logic strap);
    exp_q.delete();
    rstn                <= 1'b0;
    bus.duplex_select_n <= strap;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    wait_level(dev_ready, 1'b1, 20000);
    check_bit("full_duplex", ~strap, full_duplex);
    check_bit("ready", 1'b1, ready);
  endtask

  // monitor: every read answer takes the oldest note
  always @(negedge core_clk)
    if (rsp_valid === 1'b1 && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      if (note[8])
        check_byte("read data", note[7:0], rsp_data);
    end
    else if (rsp_valid === 1'b1)
      check_bit("unexpected read answer", 1'b0, 1'b1);

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial
  begin
    core_clk            = 1'b0;
    rstn                = 1'b0;
    seed                = 32'h9fcc5383;
    cmd                 = CMD_NONE;
    cmd_addr            = 15'h0000;
    cmd_wdata           = 8'h00;
    cmd_valid           = 1'b0;
    sock_event          = 4'h0;
    sock_event_kind     = 2'h0;
    common_event        = 1'b0;
    bus.duplex_select_n = 1'b0;
    base = '{15'h0020, 15'h0420, TXMEM_BASE, RXMEM_BASE};
    do_reset(1'b0);
    host_op(CMD_READ, COMMON_MASK, MASK_RESET, 1'b1);
    $display("test reset defaults done");
    // one byte per region, then back-to-back reads to catch aliasing
    for (i = 0; i < 4; i++)
    begin
      wdat[i] = 8'($random(seed)) | 8'h01;
      wadr[i] = base[i] + 15'($random(seed) & (i < 2 ? 31 : 255));
      host_op(CMD_WRITE, wadr[i], wdat[i], 1'b0);
    end
    for (i = 0; i < 4; i++)
      host_op(CMD_READ, wadr[i], wdat[i], 1'b1);
    $display("test regions done");
    // unmask socket 0 and the common event, leave socket 1 masked
    host_op(CMD_WRITE, COMMON_MASK, 8'h81, 1'b0);
    pulse_event(4'h0, 2'h0, 1'b1);
    wait_level(irq, 1'b1, 40);
    host_op(CMD_READ, COMMON_FLAGS, 8'h80, 1'b1);
    wait_level(irq, 1'b0, 40);
    for (k = 0; k < 4; k++)
    begin
      pulse_event(4'h1, 2'(k), 1'b0);
      wait_level(irq, 1'b1, 40);
      host_op(CMD_READ, SOCKET_BASE + {7'h00, SOCK_FLAGS}, 8'(8'h01 << k), 1'b1);
      host_op(CMD_READ, COMMON_FLAGS, 8'h00, 1'b0);
      wait_level(irq, 1'b0, 60);
    end
    pulse_event(4'h2, 2'h3, 1'b0);
    repeat (20) @(negedge core_clk);
    check_bit("masked irq", 1'b0, irq);
    host_op(CMD_READ, SOCKET_BASE + 15'h0102, 8'h08, 1'b1);
    $display("test interrupts done");
    // reset in mid-access with the other strap level
    host_op(CMD_READ, COMMON_FLAGS, 8'h00, 1'b0);
    do_reset(1'b1);
    host_op(CMD_READ, wadr[0], RESET_BYTE, 1'b1);
    host_op(CMD_READ, COMMON_MASK, MASK_RESET, 1'b1);
    repeat (20) @(negedge core_clk);
    check_bit("reads answered", 1'b1, exp_q.size() == 0);
    $display("test second reset done");
    finish_test();
  end
endmodule // testbench
`default_nettype wire
